// ==== pkg/usb_irq_pkg.sv ====
// Shared constants, source layout and types of the USB interrupt aggregator.
// Assumes a single 25 MHz system clock; all counts below are cycles of it.
package usb_irq_pkg;
   localparam int N_EP = 8;                          // Endpoints per direction
   localparam int N_USB = 7;                         // USB event sources
   localparam int N_PER = 5;                         // Codec tx/rx, serial bus, DMA0, DMA1
   localparam int N_SRC = 2 * N_EP + N_USB + N_PER + 1;
   localparam int VEC_W = 5;                         // Width of a vector register code
   // Positions in the pending vector; the vector code equals the position
   localparam int SRC_OUT = 0;
   localparam int SRC_IN = 8;
   localparam int SRC_USB = 16;
   localparam int SRC_PER = 23;
   localparam int SRC_EXT = 28;
   // Positions inside the USB status field
   localparam int ST_RESET = 0;
   localparam int ST_SUSP = 1;
   localparam int ST_RESUME = 2;
   localparam int ST_SOF = 3;
   localparam int ST_PSEUDO_FRAME_FLAG = 4;
   localparam int ST_SETUP = 5;
   localparam int ST_SETUP_OVERWRITE_FLAG = 6;
   // Values after reset
   localparam logic [N_SRC-1:0] PEND_RST = 29'h0000_0000;
   // Timing
   localparam int CLK_KHZ = 25000;
   localparam int CLK_PERIOD_PS = 1000000000 / CLK_KHZ;
   localparam int SUSPEND_MS = 5;                    // Idle time before suspend
   localparam int SUSPEND_CYC_DEF = SUSPEND_MS * CLK_KHZ;
   localparam int FRAME_US = 1000;                   // USB frame period
   localparam int FRAME_CYC_DEF = FRAME_US * CLK_KHZ / 1000;
   localparam int EXT_IRQ_PIN_CLK_KHZ = 24000;              // Least low time is one period of this
   localparam int EXT_IRQ_PIN_PERIOD_PS = 1000000000 / EXT_IRQ_PIN_CLK_KHZ;
   localparam int EXT_IRQ_PIN_LOW_CYC = (EXT_IRQ_PIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int GRST_CYC = 4;                      // Length of the global reset pulse
   // Power state of the core clock
   typedef enum logic [1:0] {
      PW_RUN = 2'b01,
      PW_SUSP = 2'b10
   } pw_state_t;
   // One-hot clear mask of a vector code; unknown codes clear nothing
   function automatic logic [N_SRC-1:0] vec_onehot(input logic [VEC_W-1:0] code);
      logic [N_SRC-1:0] m;
      m = '0;
      if (int'(code) < N_SRC) begin
         m[code] = 1'b1;
      end
      return m;
   endfunction
endpackage

// ==== pkg/ext_irq_pin_if.sv ====
// Carries the filtered external interrupt from its pin filter to the aggregator.
// Both ends run on the same clock.
`timescale 1ns/100ps
interface ext_irq_pin_if;
   logic evt;   // One-cycle pulse per recognised low-going request
   logic low;   // Filtered pin level is low (wake activity)
   modport src (output evt, output low);
   modport dst (input evt, input low);
endinterface

// ==== hdl/ext_pin_filter.sv ====
// Synchroniser and recogniser for the active-low external interrupt pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
module ext_pin_filter
   import usb_irq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_irq_pin_n,
   ext_irq_pin_if.src xo
);
   logic [2:0] sync_ff;   // Three-stage synchroniser
   logic [1:0] low_cnt_ff; // Agreed-low cycles seen
   logic armed_ff;        // Pin has returned high since last recognition
   logic evt_ff;
   logic low_ff;
   logic agree_low;
   logic agree_high;

   // Only the second and third stages are looked at
   assign agree_low = ~sync_ff[1] & ~sync_ff[2];
   assign agree_high = sync_ff[1] & sync_ff[2];

   // Synchroniser chain, idle high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_ff <= 3'h7;
      end else begin
         sync_ff <= {sync_ff[1:0], ext_irq_pin_n};
      end
   end

   // Low-time counter and one recognition per low pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_ff <= 2'h0;
         armed_ff <= 1'b1;
         evt_ff <= 1'b0;
         low_ff <= 1'b0;
      end else begin
         evt_ff <= 1'b0;
         low_ff <= agree_low;
         if (!agree_low) begin
            low_cnt_ff <= 2'h0;
         end else if (low_cnt_ff != 2'(EXT_IRQ_PIN_LOW_CYC)) begin
            low_cnt_ff <= low_cnt_ff + 2'h1;
         end
         if (agree_high) begin
            armed_ff <= 1'b1;
         end else if (armed_ff && agree_low && low_cnt_ff == 2'(EXT_IRQ_PIN_LOW_CYC - 1)) begin
            evt_ff <= 1'b1;
            armed_ff <= 1'b0;
         end
      end
   end

   assign xo.evt = evt_ff;
   assign xo.low = low_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // A recognition disarms the filter, so a held-low pin cannot repeat it
   property p_ext_irq_pin_once;
      xo.evt |-> !armed_ff ##1 !xo.evt;
   endproperty
   a_ext_irq_pin_once: assert property (p_ext_irq_pin_once) else $error("ext request pulse too long");
   property p_ext_irq_pin_low;
      xo.evt |-> $past(agree_low) && $past(agree_low, 2);
   endproperty
   a_ext_irq_pin_low: assert property (p_ext_irq_pin_low) else $error("ext request without low time");
endmodule

// ==== hdl/usb_interrupt_aggregator.sv ====
// Interrupt, reset and suspend logic in front of the embedded core.
// Assumes USB events arrive as one-cycle pulses on clk; pins are asynchronous.
`timescale 1ns/100ps
module usb_interrupt_aggregator #(
   parameter int SUSPEND_CYC = usb_irq_pkg::SUSPEND_CYC_DEF,
   parameter int FRAME_CYC = usb_irq_pkg::FRAME_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [usb_irq_pkg::N_EP-1:0] ep_out_done,
   input wire logic [usb_irq_pkg::N_EP-1:0] ep_out_iso,
   input wire logic [usb_irq_pkg::N_EP-1:0] ep_in_ack,
   input wire logic [usb_irq_pkg::N_EP-1:0] ep_in_iso,
   input wire logic [usb_irq_pkg::N_EP-1:0] ep_out_irq_en,
   input wire logic [usb_irq_pkg::N_EP-1:0] ep_in_irq_en,
   input wire logic [usb_irq_pkg::N_USB-1:0] usb_irq_en,
   input wire logic [usb_irq_pkg::N_PER-1:0] periph_irq_en,
   input wire logic [usb_irq_pkg::N_PER-1:0] periph_evt,
   input wire logic bus_reset_det,
   input wire logic bus_idle_j,
   input wire logic bus_activity,
   input wire logic sof_rx,
   input wire logic setup_ok,
   input wire logic func_reset_enable,
   input wire logic ext_irq_pin_n,
   input wire logic ext_irq_enable,
   input wire logic vec_wr,
   input wire logic [usb_irq_pkg::VEC_W-1:0] vec_code,
   input wire logic core_idle_bit,
   input wire logic [7:0] port3_pin_n,
   input wire logic [7:0] port3_wake_en,
   input wire logic port3_bit3_gpio_sel,
   output logic combined_irq_line,
   output logic second_ext_irq_input,
   output logic port3_bit3_gpio_in,
   output logic [usb_irq_pkg::N_EP-1:0] ep_out_status,
   output logic [usb_irq_pkg::N_EP-1:0] ep_in_status,
   output logic [usb_irq_pkg::N_USB-1:0] usb_status_reg,
   output logic usb_logic_rst,
   output logic global_rst,
   output logic reset_out_pin,
   output logic mcu_clk_en,
   output logic suspend_active
);
   import usb_irq_pkg::*;

   localparam int SW = $clog2(SUSPEND_CYC + 2);  // Idle counter width
   localparam int FW = $clog2(FRAME_CYC + 2);    // Frame counter width

   ext_irq_pin_if xi ();                        // Filtered external pin
   logic [N_SRC-1:0] pend_ff;            // Sticky pending sources
   logic [N_SRC-1:0] nxt_pend;
   logic [N_SRC-1:0] set_vec;            // Events arriving this cycle
   logic [N_SRC-1:0] clr_vec;            // Vector register clears
   logic [N_SRC-1:0] en_vec;             // Source enables
   logic [SW-1:0] idle_cnt_ff;           // Idle/J time counter
   logic [FW-1:0] frame_cnt_ff;          // Time since last SOF
   logic [2:0] grst_cnt_ff;              // Global reset length
   logic grst_fire;                      // Start of a global reset
   logic susp_hit;
   logic pseudo_frame_flag_hit;
   logic resume_hit;
   logic wake;
   pw_state_t pw_ff;
   logic [7:0] p3_s1_ff;                 // Port 3 synchroniser stages
   logic [7:0] p3_s2_ff;
   logic [7:0] p3_s3_ff;
   logic [7:0] p3_low;
   logic irq_ff;
   logic second_ext_irq_input_ff;
   logic gpio3_ff;
   logic usb_rst_ff;
   logic grst_ff;
   logic reset_out_pin_ff;
   logic clk_en_ff;

   // External pin filter
   ext_pin_filter u_ext_irq_pin (
      .clk(clk),
      .rst(rst),
      .ext_irq_pin_n(ext_irq_pin_n),
      .xo(xi)
   );

   // Port 3 lines come from pins: three stages, a line reads low only when stages 2 and 3 agree, except the bit 3 I/O input, taken from stage 3 alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p3_s1_ff <= 8'hFF;
         p3_s2_ff <= 8'hFF;
         p3_s3_ff <= 8'hFF;
      end else begin
         p3_s1_ff <= port3_pin_n;
         p3_s2_ff <= p3_s1_ff;
         p3_s3_ff <= p3_s2_ff;
      end
   end
   assign p3_low = ~p3_s2_ff & ~p3_s3_ff;

   // Suspend detection: idle beyond the limit, counted once per idle period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idle_cnt_ff <= '0;
      end else if (!bus_idle_j) begin
         idle_cnt_ff <= '0;
      end else if (idle_cnt_ff != SW'(SUSPEND_CYC + 1)) begin
         idle_cnt_ff <= idle_cnt_ff + SW'(1);
      end
   end
   assign susp_hit = bus_idle_j && idle_cnt_ff == SW'(SUSPEND_CYC);

   // Frame watchdog: cleared by every SOF, fires once per missed frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_cnt_ff <= '0;
      end else if (sof_rx || pseudo_frame_flag_hit || usb_rst_ff) begin
         // A bus reset restarts the watchdog along with the rest of the USB logic
         frame_cnt_ff <= '0;
      end else begin
         frame_cnt_ff <= frame_cnt_ff + FW'(1);
      end
   end
   // Fires two cycles past a whole frame, so a punctual SOF never trips it
   assign pseudo_frame_flag_hit = !sof_rx && frame_cnt_ff == FW'(FRAME_CYC + 1);

   // Wake sources that cancel suspend
   assign wake = xi.low || |(p3_low & port3_wake_en);
   assign resume_hit = pw_ff == PW_SUSP && bus_activity;

   // Power state: suspend entered on idle timeout, left on activity or wake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pw_ff <= PW_RUN;
      end else begin
         case (pw_ff)
            PW_RUN: begin
               if (susp_hit && !grst_fire) begin
                  pw_ff <= PW_SUSP;
               end
            end
            PW_SUSP: begin
               if (bus_activity || wake || grst_fire) begin
                  pw_ff <= PW_RUN;
               end
            end
            default: begin
               pw_ff <= PW_RUN;
            end
         endcase
      end
   end

   // Core clock stops only in suspend with the idle bit set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_en_ff <= 1'b1;
      end else begin
         clk_en_ff <= !(pw_ff == PW_SUSP && core_idle_bit && !wake);
      end
   end

   // Events of this cycle, one bit per source
   always_comb begin
      set_vec = '0;
      set_vec[SRC_OUT +: N_EP] = ep_out_done & ~ep_out_iso;
      set_vec[SRC_IN +: N_EP] = ep_in_ack & ~ep_in_iso;
      set_vec[SRC_USB + ST_RESET] = bus_reset_det;
      set_vec[SRC_USB + ST_SUSP] = susp_hit;
      set_vec[SRC_USB + ST_RESUME] = resume_hit;
      set_vec[SRC_USB + ST_SOF] = sof_rx;
      set_vec[SRC_USB + ST_PSEUDO_FRAME_FLAG] = pseudo_frame_flag_hit;
      // A second setup while the first is still in service is reported apart
      set_vec[SRC_USB + ST_SETUP] = setup_ok && !pend_ff[SRC_USB + ST_SETUP];
      set_vec[SRC_USB + ST_SETUP_OVERWRITE_FLAG] = setup_ok && pend_ff[SRC_USB + ST_SETUP];
      set_vec[SRC_PER +: N_PER] = periph_evt;
      set_vec[SRC_EXT] = xi.evt;
   end

   // Enables; the reset flag does not interrupt when it resets the chip
   always_comb begin
      en_vec = {ext_irq_enable, periph_irq_en, usb_irq_en, ep_in_irq_en, ep_out_irq_en};
      en_vec[SRC_USB + ST_RESET] = usb_irq_en[ST_RESET] && !func_reset_enable;
   end

   // Firmware clears one source per vector write
   assign clr_vec = vec_wr ? vec_onehot(vec_code) : '0;
   assign grst_fire = pend_ff[SRC_USB + ST_RESET] && func_reset_enable && grst_cnt_ff == 3'h0;

   // Pending bits: an event in the clearing cycle wins; global reset wipes all
   always_comb begin
      nxt_pend = (pend_ff & ~clr_vec) | set_vec;
      if (grst_fire) begin
         nxt_pend = PEND_RST;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_ff <= PEND_RST;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   // Global reset pulse on the core and the reset output
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         grst_cnt_ff <= 3'h0;
         grst_ff <= 1'b0;
         reset_out_pin_ff <= 1'b0;
      end else begin
         if (grst_fire) begin
            grst_cnt_ff <= 3'(GRST_CYC);
         end else if (grst_cnt_ff != 3'h0) begin
            grst_cnt_ff <= grst_cnt_ff - 3'h1;
         end
         grst_ff <= grst_fire || grst_cnt_ff > 3'h1;
         reset_out_pin_ff <= grst_fire || grst_cnt_ff > 3'h1;
      end
   end

   // USB logic reset: one pulse when the reset flag gets set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         usb_rst_ff <= 1'b0;
      end else begin
         usb_rst_ff <= bus_reset_det && !pend_ff[SRC_USB + ST_RESET];
      end
   end

   // Combined request; registered from the next pending value, so it rises with the pending set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_pend & en_vec);
      end
   end

   // Port 3 bit 3: second request input, or plain input when used as I/O
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         second_ext_irq_input_ff <= 1'b0;
         gpio3_ff <= 1'b1;
      end else begin
         gpio3_ff <= p3_s3_ff[3];
         second_ext_irq_input_ff <= !port3_bit3_gpio_sel && p3_low[3];
      end
   end

   // Outputs straight from flip-flops
   assign combined_irq_line = irq_ff;
   assign second_ext_irq_input = second_ext_irq_input_ff;
   assign port3_bit3_gpio_in = gpio3_ff;
   assign ep_out_status = pend_ff[SRC_OUT +: N_EP];
   assign ep_in_status = pend_ff[SRC_IN +: N_EP];
   assign usb_status_reg = pend_ff[SRC_USB +: N_USB];
   assign usb_logic_rst = usb_rst_ff;
   assign global_rst = grst_ff;
   assign reset_out_pin = reset_out_pin_ff;
   assign mcu_clk_en = clk_en_ff;
   assign suspend_active = pw_ff[1]; // Suspend bit of the one-hot state flop

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_flag_reset;
      usb_status_reg[ST_RESET] && func_reset_enable && grst_cnt_ff == 3'h0;
   endsequence
   sequence s_rst_pulse;
      reset_out_pin && usb_status_reg == '0 ##1 reset_out_pin [*3] ##1 !reset_out_pin;
   endsequence

   property p_ep_out;
      ep_out_done[0] && !ep_out_iso[0] && !grst_fire |=> ep_out_status[0];
   endproperty
   a_ep_out: assert property (p_ep_out) else $error("OUT endpoint flag not set");
   property p_iso;
      ep_in_iso[0] && !ep_in_status[0] && !(clr_vec[SRC_IN]) |=> !ep_in_status[0];
   endproperty
   a_iso: assert property (p_iso) else $error("isochronous IN raised a flag");
   property p_irq_on;
      (pend_ff & en_vec & ~clr_vec) != '0 && !grst_fire |=> combined_irq_line;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("combined request missing");
   property p_irq_off;
      (nxt_pend & en_vec) == '0 |=> !combined_irq_line;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("combined request without source");
   property p_clk_gate;
      suspend_active && core_idle_bit && !wake |=> !mcu_clk_en;
   endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("core clock not stopped");
   property p_grst;
      s_flag_reset |=> s_rst_pulse;
   endproperty
   a_grst: assert property (p_grst) else $error("global reset sequence wrong");
   property p_susp;
      $rose(usb_status_reg[ST_SUSP]) |-> $past(idle_cnt_ff) == SW'(SUSPEND_CYC);
   endproperty
   a_susp: assert property (p_susp) else $error("suspend flag at wrong idle time");
   property p_sof;
      sof_rx && !grst_fire |=> usb_status_reg[ST_SOF] && frame_cnt_ff == '0;
   endproperty
   a_sof: assert property (p_sof) else $error("SOF flag not set");
   property p_setup_overwrite_flag;
      setup_ok && usb_status_reg[ST_SETUP] && !grst_fire |=> usb_status_reg[ST_SETUP_OVERWRITE_FLAG];
   endproperty
   a_setup_overwrite_flag: assert property (p_setup_overwrite_flag) else $error("setup overwrite not flagged");
   // A fresh bus reset pulses the USB logic reset and records the flag
   property p_usb_rst;
      bus_reset_det && !usb_status_reg[ST_RESET] && !grst_fire
         |=> usb_logic_rst && usb_status_reg[ST_RESET];
   endproperty
   a_usb_rst: assert property (p_usb_rst) else $error("USB logic reset missing");
   // Host activity in suspend flags resume and leaves suspend together
   property p_resume;
      suspend_active && bus_activity && !grst_fire
         |=> usb_status_reg[ST_RESUME] && !suspend_active;
   endproperty
   a_resume: assert property (p_resume) else $error("resume not flagged");
   // Bit 3 used as plain I/O never reaches the second request input
   property p_second_ext_irq_input_gpio;
      port3_bit3_gpio_sel |=> !second_ext_irq_input;
   endproperty
   a_second_ext_irq_input_gpio: assert property (p_second_ext_irq_input_gpio) else $error("second request in I/O mode");
endmodule

// ==== tb/fw_core_model.sv ====
// Firmware side of the core: clears interrupt sources through vector writes.
// Assumes calls are made at a falling clock edge; drives for one full cycle.
`timescale 1ns/100ps
module fw_core_model (
   input wire logic clk,
   output logic vec_wr,
   output logic [usb_irq_pkg::VEC_W-1:0] vec_code
);
   import usb_irq_pkg::*;
   // Idle bus: strobe low, code not left at a meaningful value
   initial begin
      vec_wr = 1'b0;
      vec_code = 5'h1f;
   end
   // One vector write; the code is inverted afterwards so nothing relies on a stale value
   task automatic clear(input logic [VEC_W-1:0] code);
      vec_wr = 1'b1;
      vec_code = code;
      @(negedge clk);
      vec_wr = 1'b0;
      vec_code = ~code;
      // Idle cycle, so back-to-back clears never re-raise the strobe at once
      @(negedge clk);
   endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the USB interrupt aggregator.
// Assumes short suspend and frame counts; inputs change on falling edges.
`timescale 1ns/100ps
module testbench;
   import usb_irq_pkg::*;
   localparam int SUSP = 20; // Short idle span keeps the run brief
   localparam int FRM = 30; // Short frame span
   logic clk, rst, bus_reset_det, bus_idle_j, bus_activity, sof_rx, setup_ok;
   logic func_reset_enable, ext_irq_pin_n, ext_irq_enable, vec_wr, core_idle_bit;
   logic port3_bit3_gpio_sel, combined_irq_line, second_ext_irq_input, port3_bit3_gpio_in;
   logic usb_logic_rst, global_rst, reset_out_pin, mcu_clk_en, suspend_active;
   logic [7:0] ep_out_done, ep_out_iso, ep_in_ack, ep_in_iso, ep_out_irq_en, ep_in_irq_en;
   logic [7:0] port3_pin_n, port3_wake_en, ep_out_status, ep_in_status;
   logic [4:0] periph_irq_en, periph_evt, vec_code;
   logic [6:0] usb_irq_en, usb_status_reg;
   int mismatches = 0; // Failed comparisons
   int num_checks = 0; // All comparisons
   fw_core_model fw (.clk(clk), .vec_wr(vec_wr), .vec_code(vec_code));
   usb_interrupt_aggregator #(.SUSPEND_CYC(SUSP), .FRAME_CYC(FRM)) uut (
      .clk(clk), .rst(rst), .ep_out_done(ep_out_done), .ep_out_iso(ep_out_iso),
      .ep_in_ack(ep_in_ack), .ep_in_iso(ep_in_iso), .ep_out_irq_en(ep_out_irq_en),
      .ep_in_irq_en(ep_in_irq_en), .usb_irq_en(usb_irq_en), .periph_irq_en(periph_irq_en),
      .periph_evt(periph_evt), .bus_reset_det(bus_reset_det), .bus_idle_j(bus_idle_j),
      .bus_activity(bus_activity), .sof_rx(sof_rx), .setup_ok(setup_ok),
      .func_reset_enable(func_reset_enable), .ext_irq_pin_n(ext_irq_pin_n),
      .ext_irq_enable(ext_irq_enable), .vec_wr(vec_wr), .vec_code(vec_code),
      .core_idle_bit(core_idle_bit), .port3_pin_n(port3_pin_n), .port3_wake_en(port3_wake_en),
      .port3_bit3_gpio_sel(port3_bit3_gpio_sel), .combined_irq_line(combined_irq_line),
      .second_ext_irq_input(second_ext_irq_input), .port3_bit3_gpio_in(port3_bit3_gpio_in),
      .ep_out_status(ep_out_status), .ep_in_status(ep_in_status),
      .usb_status_reg(usb_status_reg), .usb_logic_rst(usb_logic_rst), .global_rst(global_rst),
      .reset_out_pin(reset_out_pin), .mcu_clk_en(mcu_clk_en), .suspend_active(suspend_active));
   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Compare one value, count it and report a difference
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      if (mismatches == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // One endpoint event: direction, endpoint, iso transfer, enabled
   task automatic ep_case(input int d, input int i, input bit iso, input bit en);
      logic [7:0] e;
      e = iso ? 8'h00 : 8'h01 << i;
      ep_out_irq_en = en ? 8'hff : 8'h00;
      ep_in_irq_en = en ? 8'hff : 8'h00;
      ep_out_iso = iso ? 8'hff : 8'h00;
      ep_in_iso = iso ? 8'hff : 8'h00;
      if (d == 1) ep_in_ack[i] = 1'b1;
      else ep_out_done[i] = 1'b1;
      @(negedge clk);
      ep_in_ack = 8'h00;
      ep_out_done = 8'h00;
      chk("ep status", d ? ep_in_status : ep_out_status, e);
      chk("irq", combined_irq_line, e != 0 && en);
      fw.clear(5'h1d); // Unused code must clear nothing
      chk("ep held", d ? ep_in_status : ep_out_status, e);
      fw.clear(5'(d * 8 + i));
      chk("ep clr", d ? ep_in_status : ep_out_status, 0);
      chk("irq clr", combined_irq_line, 0);
   endtask
   // Peripheral sources reach the combined request and clear by vector
   task automatic periph_case();
      for (int p = 0; p < 5; p++) begin
         periph_evt[p] = 1'b1;
         @(negedge clk);
         periph_evt = 5'h00;
         chk("per irq", combined_irq_line, 1);
         fw.clear(5'(SRC_PER + p));
         chk("per clr", combined_irq_line, 0);
      end
   endtask
   // Bus reset: interrupt path, then global reset path
   task automatic reset_case();
      int n;
      usb_irq_en = 7'h01;
      bus_reset_det = 1'b1;
      @(negedge clk);
      bus_reset_det = 1'b0;
      chk("rst flag", usb_status_reg[ST_RESET], 1);
      chk("usb rst", usb_logic_rst, 1);
      chk("rst irq", combined_irq_line, 1);
      chk("grst", global_rst, 0);
      fw.clear(5'(SRC_USB + ST_RESET));
      chk("rst clr", usb_status_reg[ST_RESET], 0);
      chk("rst irq clr", combined_irq_line, 0);
      func_reset_enable = 1'b1;
      bus_reset_det = 1'b1;
      @(negedge clk);
      bus_reset_det = 1'b0;
      n = 0;
      repeat (8) begin
         if (global_rst === 1'b1 && reset_out_pin === 1'b1) n++;
         @(negedge clk);
      end
      chk("grst len", n, GRST_CYC);
      chk("sta cleared", usb_status_reg, 0);
      func_reset_enable = 1'b0;
      usb_irq_en = 7'h00;
   endtask
   // Setup packet, then a second one while the flag is still set
   task automatic setup_case();
      usb_irq_en = 7'h20;
      for (int k = 0; k < 2; k++) begin
         setup_ok = 1'b1;
         @(negedge clk);
         setup_ok = 1'b0;
         chk("setup", usb_status_reg[ST_SETUP], 1);
         chk("overwrite", usb_status_reg[ST_SETUP_OVERWRITE_FLAG], k);
         chk("setup irq", combined_irq_line, 1);
      end
      fw.clear(5'(SRC_USB + ST_SETUP));
      chk("setup irq clr", combined_irq_line, 0);
      fw.clear(5'(SRC_USB + ST_SETUP_OVERWRITE_FLAG));
      chk("sta setup clr", usb_status_reg[6:5], 0);
      usb_irq_en = 7'h00;
   endtask
   // Frame start flag, then the pseudo flag once frames stop
   task automatic sof_case();
      for (int k = 0; k < 3; k++) begin
         sof_rx = 1'b1;
         @(negedge clk);
         sof_rx = 1'b0;
         chk("sof", usb_status_reg[ST_SOF], 1);
         if (k == 0) fw.clear(5'(SRC_USB + ST_PSEUDO_FRAME_FLAG));
         repeat (18) @(negedge clk);
         chk("no pseudo_frame_flag", usb_status_reg[ST_PSEUDO_FRAME_FLAG], 0);
      end
      usb_irq_en = 7'h10;
      repeat (FRM + 4) @(negedge clk);
      chk("pseudo_frame_flag", usb_status_reg[ST_PSEUDO_FRAME_FLAG], 1);
      chk("pseudo_frame_flag irq", combined_irq_line, 1);
      fw.clear(5'(SRC_USB + ST_PSEUDO_FRAME_FLAG));
      fw.clear(5'(SRC_USB + ST_SOF));
      chk("pseudo_frame_flag clr", usb_status_reg[4:3], 0);
      usb_irq_en = 7'h00;
   endtask
   // Suspend, clock stop and wake by bus activity or by an enabled port line
   task automatic susp_case();
      for (int m = 0; m < 2; m++) begin
         bus_idle_j = 1'b1;
         repeat (SUSP + 4) @(negedge clk);
         bus_idle_j = 1'b0;
         chk("susp", usb_status_reg[ST_SUSP], 1);
         chk("susp act", suspend_active, 1);
         core_idle_bit = 1'b1;
         repeat (2) @(negedge clk);
         chk("clk stop", mcu_clk_en, 0);
         if (m == 0) begin
            bus_activity = 1'b1;
            @(negedge clk);
            bus_activity = 1'b0;
         end else begin
            port3_wake_en[4] = 1'b1;
            port3_pin_n[4] = 1'b0;
         end
         repeat (6) @(negedge clk);
         chk("resume", usb_status_reg[ST_RESUME], m == 0);
         chk("clk run", mcu_clk_en, 1);
         chk("susp left", suspend_active, 0);
         core_idle_bit = 1'b0;
         port3_pin_n = 8'hff;
         port3_wake_en = 8'h00;
         fw.clear(5'(SRC_USB + ST_SUSP));
         fw.clear(5'(SRC_USB + ST_RESUME));
      end
   endtask
   // Active-low external pin: gating, single recognition and re-arm
   task automatic ext_case();
      ext_irq_pin_n = 1'b0;
      repeat (10) @(negedge clk);
      chk("ext masked", combined_irq_line, 0);
      ext_irq_enable = 1'b1;
      @(negedge clk);
      chk("ext irq", combined_irq_line, 1);
      fw.clear(5'(SRC_EXT));
      repeat (10) @(negedge clk);
      chk("ext held low", combined_irq_line, 0);
      ext_irq_pin_n = 1'b1;
      repeat (6) @(negedge clk);
      ext_irq_pin_n = 1'b0;
      repeat (10) @(negedge clk);
      chk("ext rearm", combined_irq_line, 1);
      ext_irq_pin_n = 1'b1;
      fw.clear(5'(SRC_EXT));
      ext_irq_enable = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   // Second request input on port 3 bit 3 and its plain I/O use
   task automatic port3_case();
      port3_pin_n[3] = 1'b0;
      repeat (5) @(negedge clk);
      chk("second_ext_irq_input", second_ext_irq_input, 1);
      chk("gpio in", port3_bit3_gpio_in, 0);
      port3_bit3_gpio_sel = 1'b1;
      repeat (2) @(negedge clk);
      chk("second_ext_irq_input gpio", second_ext_irq_input, 0);
      port3_pin_n[3] = 1'b1;
      port3_bit3_gpio_sel = 1'b0;
      repeat (5) @(negedge clk);
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      {ep_out_done, ep_out_iso, ep_in_ack, ep_in_iso} = '0;
      {ep_out_irq_en, ep_in_irq_en, port3_wake_en} = '0;
      {bus_reset_det, bus_idle_j, bus_activity, sof_rx, setup_ok} = '0;
      {func_reset_enable, ext_irq_enable, core_idle_bit, port3_bit3_gpio_sel} = '0;
      usb_irq_en = 7'h00;
      periph_irq_en = 5'h1f;
      periph_evt = 5'h00;
      ext_irq_pin_n = 1'b1;
      port3_pin_n = 8'hff;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk("clk en rst", mcu_clk_en, 1);
      for (int k = 0; k < 8; k++) ep_case(k % 2, k, k == 5 || k == 6, k != 3);
      periph_case();
      setup_case();
      sof_case();
      susp_case();
      ext_case();
      port3_case();
      reset_case();
      close_out();
   end
   // Watchdog far beyond the expected run of about 310 cycles
   initial begin
      #800000;
      mismatches++;
      close_out();
   end
endmodule
